/* File: sim/fws_flash_model.sv */
`timescale 1ns/10ps
module fws_flash_model #(
    parameter int         BUSY_READS = 4,
    parameter logic [7:0] LOCK_CODE  = 8'h80,
    parameter logic [7:0] PROT_SEC   = 8'h0F  // Sector that refuses writes
) (
    input  wire logic [19:0] i_addr,   // Address pins
    input  wire logic [15:0] i_dq,     // Data from the controller
    input  wire logic        i_ce_n,   // Chip select
    input  wire logic        i_we_n,   // Write strobe
    input  wire logic        i_oe_n,   // Output enable
    output logic [15:0]      o_dq,     // Data towards the controller
    output logic             o_pull_n  // Low while sinking ready_busy_n
);
    logic [15:0] mem [0:255];
    logic [19:0] wa;
    logic [15:0] pd, last_out;
    logic [7:0]  esec;
    logic        arm, ers_arm, ers, susp, asel, tog, tog2, bad, byp, rd_on;
    int          busy;
    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
        {arm, ers_arm, ers, susp, asel, tog, tog2, bad, byp, rd_on} = '0;
        {pd, last_out, esec, wa} = '0;
        busy = 0;
    end
    always @(negedge i_we_n) if (!i_ce_n) wa = i_addr;
    always @(negedge i_ce_n) if (!i_we_n) wa = i_addr;
    always @(posedge i_we_n) if (!i_ce_n) begin
        if (arm) begin
            arm = 0;
            pd = i_dq;
            busy = BUSY_READS;
            bad = |(i_dq & ~mem[wa[7:0]]);
            if (wa[19:12] != PROT_SEC)
                mem[wa[7:0]] = mem[wa[7:0]] & i_dq;
        end else case (i_dq[7:0])
            8'hA0: arm = 1;
            8'h80: ers_arm = 1;
            8'h30: if (ers_arm) begin
                ers = 1;
                ers_arm = 0;
                esec = wa[19:12];
                busy = BUSY_READS;
            end else susp = 0;
            8'hB0: if (ers) susp = 1;
            8'h20: byp = 1;
            8'h90: if (byp) byp = 0;
                else asel = 1;
            8'hF0: {asel, bad, busy} = '0;
            default: ;
        endcase
    end
    // Either strobe may end a read; both can rise on one edge
    always @(i_ce_n or i_oe_n) if (!i_ce_n && !i_oe_n) rd_on = 1;
    else if (rd_on) begin
        rd_on = 0;
        if (busy > 0 && !susp) begin
            tog = ~tog;
            if (!bad) busy = busy - 1;
            if (busy == 0) ers = 0;
        end
        if (ers && i_addr[19:12] == esec) tog2 = ~tog2;
    end
    always @(o_dq) if (!i_ce_n && !i_oe_n) last_out = o_dq;
    always_comb begin
        if (i_ce_n || i_oe_n) o_dq = ~last_out;
        else if (asel)
            o_dq = {8'hC3, i_addr[7:0] == 8'h03 ? LOCK_CODE : 8'h01};
        else if (busy > 0 && ers)
            o_dq = {8'h00, susp, tog & ~susp, 3'b000, tog2, 2'b00};
        else if (busy > 0)
            o_dq = {8'h00, ~pd[7], tog, bad, 5'b00000};
        else o_dq = mem[i_addr[7:0]];
    end
    assign o_pull_n = !(busy > 0 && !susp);
endmodule : fws_flash_model

/* File: sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import fws_pkg::*;
    logic        mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, st;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid, seen_pin;
    logic [1:0]  bresp, rresp;
    logic [19:0] faddr;
    logic [15:0] dq_out, dq_flash, dq_in;
    logic        dq_oe_n, ce_n, we_n, oe_n, pull_n, ready_busy_n;
    int          failures, n_checks, cyc;
    assign dq_in = dq_oe_n ? dq_flash : dq_out;
    assign ready_busy_n = pull_n;  // Pull-up unless the flash sinks it
    fws_ctrl DUT (.i_mclk(mclk), .i_resetn(resetn), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .o_flash_addr(faddr), .o_dq_out(dq_out),
        .o_dq_oe_n(dq_oe_n), .i_dq_in(dq_in), .o_ce_n(ce_n),
        .o_we_n(we_n), .o_oe_n(oe_n), .i_ready_busy_n(ready_busy_n));
    fws_flash_model flash (.i_addr(faddr), .i_dq(dq_out), .i_ce_n(ce_n),
        .i_we_n(we_n), .i_oe_n(oe_n), .o_dq(dq_flash), .o_pull_n(pull_n));
    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        {aw, w} = 2'b11;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        while (aw || w) begin
            @(posedge mclk);
            if (aw && awready) begin aw = 0; awvalid <= 0; end
            if (w && wready) begin w = 0; wvalid <= 0; end
        end
        bready <= 1;
        do @(posedge mclk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, bresp}, 32'h0000_0000);
        bready <= 0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge mclk);
        d = rdata;
        rready <= 0;
        @(posedge mclk);
    endtask : axi_rd
    // Issue one operation and poll STATUS until busy clears
    task automatic run_op(input logic [3:0] op, input logic [19:0] a,
                          input logic [15:0] d);
        axi_wr(ADDR_OFS, {12'h000, a});
        axi_wr(DATA_OFS, {16'h0000, d});
        axi_wr(CMD_OFS, {28'h000_0000, op});
        seen_pin = 0;
        do begin
            axi_rd(STATUS_OFS, st);
            if (st[3] === 1'b1) seen_pin = 1;
        end while (st[2] !== 1'b0);
    endtask : run_op
    task automatic t_idle;
        axi_rd(STATUS_OFS, st);
        chk("idle status", st, 32'h0000_0000);
        axi_rd(8'h20, st);
        chk("unmapped", st, 32'h0000_0000);
    endtask : t_idle
    task automatic t_program;
        run_op(OP_PROGRAM, 20'h0_0010, 16'h5A3C);
        chk("prog status", st[3:0], 4'b0001);
        chk("pin seen low", seen_pin, 1'b1);
        chk("array word", flash.mem[16], 16'h5A3C);
        run_op(OP_READ, 20'h0_0010, 16'h0000);
        axi_rd(RDATA_OFS, st);
        chk("read back", st[15:0], 16'h5A3C);
    endtask : t_program
    task automatic t_fail;
        run_op(OP_PROGRAM, 20'h0_0010, 16'hFFFF);
        chk("fail bit", st[1:0], 2'b11);
        run_op(OP_RESET, 20'h0_0000, 16'h0000);
        chk("pin released", ready_busy_n, 1'b1);
    endtask : t_fail
    task automatic t_autosel;
        run_op(OP_AUTOSEL, 20'h0_0003, 16'h0000);
        axi_rd(RDATA_OFS, st);
        chk("lock code", st[7:0], 8'h80);
        run_op(OP_RESET, 20'h0_0000, 16'h0000);
        run_op(OP_AUTOSEL, 20'h0_0002, 16'h0000);
        axi_rd(RDATA_OFS, st);
        chk("protect code", st[7:0], 8'h01);
        run_op(OP_RESET, 20'h0_0000, 16'h0000);
        chk("autosel left", flash.asel, 1'b0);
    endtask : t_autosel
    task automatic t_erase;
        run_op(OP_SECERASE, 20'h0_5000, 16'h0000);
        chk("erase status", st[3:0], 4'b0001);
        chk("erase pin", seen_pin, 1'b1);
        chk("sector", flash.esec, 8'h05);
    endtask : t_erase
    task automatic t_protect;
        run_op(OP_PROGRAM, 20'h0_F010, 16'h0000);
        chk("prot status", st[3:0], 4'b0001);
        chk("prot word", flash.mem[16], 16'h5A3C);
    endtask : t_protect
    task automatic t_bypass;
        run_op(OP_BYP_ENTER, 20'h0_0000, 16'h0000);
        run_op(OP_BYP_PROG, 20'h0_0020, 16'h1234);
        chk("byp status", st[3:0], 4'b0001);
        run_op(OP_BYP_EXIT, 20'h0_0000, 16'h0000);
        chk("bypass left", flash.byp, 1'b0);
        run_op(OP_READ, 20'h0_0020, 16'h0000);
        axi_rd(RDATA_OFS, st);
        chk("byp word", st[15:0], 16'h1234);
    endtask : t_bypass
    initial begin
        {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {failures, n_checks, cyc} = '0;
        repeat (3) @(posedge mclk);
        resetn <= 1;
        repeat (3) @(posedge mclk);
        t_idle();
        t_program();
        t_fail();
        t_protect();
        t_autosel();
        t_erase();
        t_bypass();
        give_verdict();
    end
endmodule : testbench

/* File: src/fws_ctrl.sv */
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Contract
// R1: Hold address before write strobe fall, data past its rise.
// R2: All command cycles are writes except array read and autoselect read.
// R3: Upper data byte and high address bits in command cycles are don't care.
// R4: Address bits 19..12 pick the sector for erase and protect verify.
// R5: Reset command returns autoselect or timed-out bank to reading.
// R6: Autoselect read uses bank address; upper byte of result undefined.
// R7: Factory lock query yields 80h locked, 00h unlocked.
// R8: Protect verify yields 01h protected, 00h unprotected.
// R9: Enter bypass before bypass program; exit with bypass reset.
// R10: Erase suspend only during sector erase, with bank address. CMD is ignored while busy, so suspend is only sent when idle.
// R11: Program status bit 7 is complement until done; poll program address.
// R12: Protected program shows polling about 1 us, then array read.
// R13: Erase drives bit 7 low; poll inside an erased sector.
// R14: All-protected erase shows busy about 100 us, then array read.
// R15: Partly protected erase skips protected sectors; their status unreliable.
// R16: Bit 7 may settle first; reread for valid data on all bits.
// R17: Ready/busy pin low while program or erase runs.
// R18: Bit 6 inverts on each read while algorithm runs.
// R19: Bit 6 stops in suspend, resumes for suspend programming.
// R20: Protected program toggles bit 6 about 1 us.
// R21: Bit 2 toggles only inside sectors selected for erase.
// R22: Status valid from rising write strobe of last command cycle.
// R23: Bit 5 high means the operation exceeded its limit and failed.
// R24: Status reads must address the busy bank.
module fws_ctrl
    import fws_pkg::*;
(
    input  wire logic        i_mclk,         // 250 MHz clock
    input  wire logic        i_resetn,       // Async reset, active low
    input  wire logic [7:0]  i_awaddr,       // AXI write address
    input  wire logic        i_awvalid,      // AXI write address valid
    output logic             o_awready,      // AXI write address ready
    input  wire logic [31:0] i_wdata,        // AXI write data
    input  wire logic [3:0]  i_wstrb,        // AXI write strobes
    input  wire logic        i_wvalid,       // AXI write data valid
    output logic             o_wready,       // AXI write data ready
    output logic [1:0]       o_bresp,        // AXI write response
    output logic             o_bvalid,       // AXI write response valid
    input  wire logic        i_bready,       // AXI write response ready
    input  wire logic [7:0]  i_araddr,       // AXI read address
    input  wire logic        i_arvalid,      // AXI read address valid
    output logic             o_arready,      // AXI read address ready
    output logic [31:0]      o_rdata,        // AXI read data
    output logic [1:0]       o_rresp,        // AXI read response
    output logic             o_rvalid,       // AXI read data valid
    input  wire logic        i_rready,       // AXI read data ready
    output logic [19:0]      o_flash_addr,   // Flash address
    output logic [15:0]      o_dq_out,       // Flash data out
    output logic             o_dq_oe_n,      // Data drive enable, low=drive
    input  wire logic [15:0] i_dq_in,        // Flash data in
    output logic             o_ce_n,         // Flash chip select
    output logic             o_we_n,         // Flash write strobe
    output logic             o_oe_n,         // Flash output enable
    input  wire logic        i_ready_busy_n  // Ready/busy pin level
);

    // ******************************************
    // Reset synchroniser
    // ******************************************
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ******************************************
    // Command sequence table
    // ******************************************
    function automatic fws_cycle_type seq_cycle(input logic [3:0] op,
            input logic [2:0] idx, input logic [19:0] a,
            input logic [15:0] d);
        fws_cycle_type c;
        logic [19:0] bank;
        c = '{addr: 20'h0_0555, data: 16'h0000, write: 1'b1,
              last: 1'b0, poll: 1'b0};
        bank = {a[19:12], 12'h000};
        if (idx == 3'd1) begin
            c.addr = 20'h0_02AA;
            c.data = 16'h0055;
        end else if (idx == 3'd0) begin
            c.data = 16'h00AA;
        end
        case (op)
            OP_READ: begin
                c = '{addr: a, data: 16'h0000, write: 1'b0,
                      last: 1'b1, poll: 1'b0};          // [R2]
            end
            OP_RESET: begin
                c = '{addr: 20'h0_0000, data: 16'h00F0, write: 1'b1,
                      last: 1'b1, poll: 1'b0};          // [R5]
            end
            OP_SUSPEND, OP_RESUME: begin
                c.addr = bank;                         // [R10]
                c.data = (op == OP_SUSPEND) ? 16'h00B0 : 16'h0030;
                c.last = 1'b1;
            end
            OP_AUTOSEL: begin
                if (idx == 3'd2) begin
                    c.addr = bank | 20'h0_0555;
                    c.data = 16'h0090;
                end else if (idx == 3'd3) begin
                    c.addr = a;                        // [R6]
                    c.write = 1'b0;                    // [R2]
                    c.last = 1'b1;
                end
            end
            OP_BYP_ENTER: begin
                if (idx == 3'd2) begin
                    c.data = 16'h0020;
                    c.last = 1'b1;
                end
            end
            OP_PROGRAM: begin
                if (idx == 3'd2) begin
                    c.data = 16'h00A0;
                end else if (idx == 3'd3) begin
                    c = '{addr: a, data: d, write: 1'b1,
                          last: 1'b1, poll: 1'b1};      // [R11]
                end
            end
            OP_BYP_PROG: begin
                if (idx == 3'd0) begin
                    c.data = 16'h00A0;                 // [R9]
                end else begin
                    c = '{addr: a, data: d, write: 1'b1,
                          last: 1'b1, poll: 1'b1};
                end
            end
            OP_BYP_EXIT: begin
                c.addr = (idx == 3'd0) ? bank : 20'h0_0000;
                c.data = (idx == 3'd0) ? 16'h0090 : 16'h0000;
                c.last = (idx == 3'd1);                // [R9]
            end
            default: begin
                if (idx == 3'd2) begin
                    c.data = 16'h0080;
                end else if (idx == 3'd5) begin
                    c.addr = (op == OP_SECERASE) ? bank : 20'h0_0555;
                    c.data = (op == OP_SECERASE) ? 16'h0030 : 16'h0010;
                    c.last = 1'b1;                     // [R4]
                    c.poll = 1'b1;
                end else if (idx == 3'd3) begin
                    c.data = 16'h00AA;
                    c.addr = 20'h0_0555;
                end else if (idx == 3'd4) begin
                    c.addr = 20'h0_02AA;
                    c.data = 16'h0055;
                end
            end
        endcase
        return c;
    endfunction : seq_cycle

    // ******************************************
    // Software registers
    // ******************************************
    logic [3:0]  cmd_op;
    logic [19:0] cmd_addr;
    logic [15:0] cmd_data;
    logic        start;
    logic        busy;
    logic        done;
    logic        fail;
    logic [15:0] rd_value;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;

    assign o_awready = !aw_got && !o_bvalid;
    assign o_wready  = !w_got && !o_bvalid;
    assign o_bresp   = 2'b00;
    assign o_rresp   = 2'b00;
    assign o_arready = !o_rvalid;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            aw_addr  <= 8'h00;
            w_data   <= 32'h0000_0000;
            o_bvalid <= 1'b0;
            cmd_op   <= 4'h0;
            cmd_addr <= 20'h0_0000;
            cmd_data <= 16'h0000;
            start    <= 1'b0;
        end else begin
            start <= 1'b0;
            if (i_awvalid && o_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_got  <= 1'b1;
                w_data <= i_wdata;
            end
            if (aw_got && w_got) begin
                aw_got   <= 1'b0;
                w_got    <= 1'b0;
                o_bvalid <= 1'b1;
                if (aw_addr == ADDR_OFS) begin
                    cmd_addr <= w_data[19:0];
                end else if (aw_addr == DATA_OFS) begin
                    cmd_data <= w_data[15:0];
                end else if (aw_addr == CMD_OFS && !busy) begin
                    cmd_op <= w_data[3:0];
                    start  <= 1'b1;
                end
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
        end else begin
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                if (i_araddr == STATUS_OFS) begin
                    o_rdata <= {28'h000_0000, !i_ready_busy_n,
                                busy, fail, done};     // [R17]
                end else if (i_araddr == RDATA_OFS) begin
                    o_rdata <= {16'h0000, rd_value};
                end else if (i_araddr == ADDR_OFS) begin
                    o_rdata <= {12'h000, cmd_addr};
                end else if (i_araddr == DATA_OFS) begin
                    o_rdata <= {16'h0000, cmd_data};
                end else begin
                    o_rdata <= 32'h0000_0000;
                end
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ******************************************
    // Flash bus sequencer
    // ******************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_POLL_A, ST_POLL_B
    } fws_state_type;

    fws_state_type state;
    fws_cycle_type cur;
    logic [2:0]    idx;
    logic [3:0]    tmr;
    logic [7:0]    poll_prev;
    logic          poll_first;
    logic          poll_last;
    logic          dq5_seen;

    assign cur = seq_cycle(cmd_op, idx, cmd_addr, cmd_data);
    assign busy = (state != ST_IDLE);

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= ST_IDLE;
            idx          <= 3'd0;
            tmr          <= 4'h0;
            o_ce_n       <= 1'b1;
            o_we_n       <= 1'b1;
            o_oe_n       <= 1'b1;
            o_dq_oe_n    <= 1'b1;
            o_dq_out     <= 16'h0000;
            o_flash_addr <= 20'h0_0000;
            rd_value     <= 16'h0000;
            poll_prev    <= 8'h00;
            poll_first   <= 1'b0;
            poll_last    <= 1'b0;
            dq5_seen     <= 1'b0;
            done         <= 1'b0;
            fail         <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        idx   <= 3'd0;
                        tmr   <= SETUP_CYC;
                        done  <= 1'b0;
                        fail  <= 1'b0;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // Address settles before write strobe or output enable falls; chip select falls with it
                    o_flash_addr <= cur.addr;                  // [R1]
                    o_dq_out     <= cur.data;
                    o_dq_oe_n    <= !cur.write;
                    o_ce_n       <= 1'b0;
                    if (tmr == 4'h0) begin
                        o_we_n <= !cur.write;
                        o_oe_n <= cur.write;
                        tmr    <= cur.write ? PULSE_CYC : ACCESS_CYC;
                        state  <= ST_PULSE;
                    end else begin
                        tmr <= tmr - 4'h1;
                    end
                end
                ST_PULSE: begin
                    if (tmr == 4'h0) begin
                        // Strobe rises while data is still driven
                        o_we_n <= 1'b1;                        // [R1]
                        o_oe_n <= 1'b1;
                        if (!cur.write) begin
                            rd_value <= i_dq_in;               // [R16]
                        end
                        tmr   <= HOLD_CYC;
                        state <= ST_HOLD;
                    end else begin
                        tmr <= tmr - 4'h1;
                    end
                end
                ST_HOLD: begin
                    if (tmr == 4'h0) begin
                        o_ce_n    <= 1'b1;
                        o_dq_oe_n <= 1'b1;
                        if (!cur.last) begin
                            idx   <= idx + 3'd1;
                            tmr   <= SETUP_CYC;
                            state <= ST_SETUP;
                        end else if (cur.poll) begin
                            // Status valid after last write rise
                            o_flash_addr <= cur.addr;  // [R13] [R22] [R24]
                            poll_first <= 1'b1;
                            poll_last  <= 1'b0;
                            dq5_seen   <= 1'b0;
                            tmr   <= SETUP_CYC;
                            state <= ST_POLL_A;
                        end else begin
                            done  <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end else begin
                        tmr <= tmr - 4'h1;
                    end
                end
                ST_POLL_A: begin
                    // Toggle poll read: bit 6 compared across reads
                    o_ce_n <= 1'b0;
                    if (tmr == 4'h0) begin
                        o_oe_n <= 1'b0;
                        tmr    <= ACCESS_CYC;
                        state  <= ST_POLL_B;
                    end else begin
                        tmr <= tmr - 4'h1;
                    end
                end
                ST_POLL_B: begin
                    if (tmr == 4'h0) begin
                        o_oe_n     <= 1'b1;
                        o_ce_n     <= 1'b1;
                        poll_prev  <= i_dq_in[7:0];
                        poll_first <= 1'b0;
                        tmr        <= SETUP_CYC;
                        state      <= ST_POLL_A;
                        if (poll_last) begin
                            // Read after toggling stopped: all bits valid
                            rd_value <= i_dq_in;               // [R16]
                            done     <= 1'b1;
                            state    <= ST_IDLE;
                        end else if (!poll_first) begin
                            if (i_dq_in[6] == poll_prev[6]) begin
                                poll_last <= 1'b1;             // [R18]
                            end else if (dq5_seen) begin
                                // Still toggling after limit flag
                                fail  <= 1'b1;                 // [R23] [R5]
                                done  <= 1'b1;
                                state <= ST_IDLE;
                            end else if (i_dq_in[5]) begin
                                // Limit flag: recheck on a fresh pair
                                dq5_seen   <= 1'b1;
                                poll_first <= 1'b1;
                            end
                        end
                    end else begin
                        tmr <= tmr - 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ******************************************
    // Checks
    // ******************************************
    strobe_excl_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        !(!o_we_n && !o_oe_n)) else $error("both strobes low"); // [R2]
    we_ce_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        !o_we_n |-> !o_ce_n) else $error("write without select"); // [R1]
    data_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        $rose(o_we_n) |-> !o_dq_oe_n && $stable(o_dq_out))
        else $error("data moved at write rise"); // [R1]
    addr_stable_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        !o_we_n && !$past(o_we_n) |-> $stable(o_flash_addr))
        else $error("address moved in pulse"); // [R1]
    read_nodrive_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        !o_oe_n |-> o_dq_oe_n) else $error("bus fight on read"); // [R6]
    fail_done_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        fail |-> done) else $error("fail without done"); // [R23]
    poll_after_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        state == ST_POLL_A |-> o_we_n) else $error("write in poll"); // [R22]
    bvalid_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        o_bvalid && !i_bready |=> o_bvalid) else $error("bvalid dropped");

    write_cov: cover property (@(posedge i_mclk) $fell(o_we_n));
    poll_cov: cover property (@(posedge i_mclk) state == ST_POLL_B);
    fail_cov: cover property (@(posedge i_mclk) $rose(fail));

endmodule : fws_ctrl

/* File: src/fws_pkg.sv */
package fws_pkg;

    // ******************************************
    // Register map of the controller (AXI4-Lite)
    // ******************************************
    localparam logic [7:0] CMD_OFS    = 8'h00;
    localparam logic [7:0] ADDR_OFS   = 8'h04;
    localparam logic [7:0] DATA_OFS   = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] RDATA_OFS  = 8'h10;

    // ******************************************
    // Command codes written to CMD
    // ******************************************
    localparam logic [3:0] OP_READ     = 4'h1;
    localparam logic [3:0] OP_RESET    = 4'h2;
    localparam logic [3:0] OP_PROGRAM  = 4'h3;
    localparam logic [3:0] OP_SECERASE = 4'h4;
    localparam logic [3:0] OP_CHIPERASE = 4'h5;
    localparam logic [3:0] OP_SUSPEND  = 4'h6;
    localparam logic [3:0] OP_RESUME   = 4'h7;
    localparam logic [3:0] OP_AUTOSEL  = 4'h8;
    localparam logic [3:0] OP_BYP_ENTER = 4'h9;
    localparam logic [3:0] OP_BYP_PROG = 4'hA;
    localparam logic [3:0] OP_BYP_EXIT = 4'hB;

    // ******************************************
    // Flash bus timing in cycles, status and address widths
    // ******************************************
    localparam logic [3:0] SETUP_CYC  = 4'h2;
    localparam logic [3:0] PULSE_CYC  = 4'h4;
    localparam logic [3:0] HOLD_CYC   = 4'h2;
    localparam logic [3:0] ACCESS_CYC = 4'h6;
    localparam logic [3:0] STATUS_BITS = 4'h8;
    localparam int         ADDR_W     = 20;

    localparam int STATUS_DONE_BIT  = 0;
    localparam int STATUS_FAIL_BIT  = 1;
    localparam int STATUS_BUSY_BIT  = 2;

    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] data;
        logic        write;
        logic        last;
        logic        poll;
    } fws_cycle_type;

endpackage : fws_pkg
